// file: rtl/sch_pkg.sv
// Constants shared by the health-monitoring command handler and its helpers.
package sch_pkg;
    // Command opcode and sub-operation selectors.
    localparam logic [7:0] CMD_HEALTH      = 8'hb0;
    localparam logic [7:0] SUB_READ_DATA   = 8'hd0;
    localparam logic [7:0] SUB_ENABLE      = 8'hd8;
    localparam logic [7:0] SUB_DISABLE     = 8'hd9;
    // Signature expected in the cylinder registers.
    localparam logic [7:0] SIG_MID         = 8'h4f;
    localparam logic [7:0] SIG_HIGH        = 8'hc2;
    // Status bit positions.
    localparam int unsigned ST_BSY         = 7;
    localparam int unsigned ST_DRDY        = 6;
    localparam int unsigned ST_DF          = 5;
    localparam int unsigned ST_DRQ         = 3;
    localparam int unsigned ST_ERR         = 0;
    // Error and device-select bit positions.
    localparam int unsigned ER_ABRT        = 2;
    localparam int unsigned DV_DEV         = 4;
    // Reset values of the visible registers.
    localparam logic [7:0] STATUS_RST      = 8'h40;
    localparam logic [7:0] ERROR_RST       = 8'h00;
    localparam logic [7:0] DEVSEL_RST      = 8'h00;
    // Data structure layout, byte offsets.
    localparam int unsigned SEC_BYTES      = 512;
    localparam logic [8:0] B_REV_LO        = 9'h000;
    localparam logic [8:0] B_REV_HI        = 9'h001;
    localparam logic [8:0] B_OFFL_STAT     = 9'h16a;
    localparam logic [8:0] B_TEST_STAT     = 9'h16b;
    localparam logic [8:0] B_TIME_LO       = 9'h16c;
    localparam logic [8:0] B_TIME_HI       = 9'h16d;
    localparam logic [8:0] B_ERRLOG_CAP    = 9'h172;
    localparam logic [8:0] B_POLL_SHORT    = 9'h174;
    localparam logic [8:0] B_POLL_EXT      = 9'h175;
    localparam logic [8:0] B_POLL_CONV     = 9'h176;
    localparam logic [8:0] B_CHECKSUM      = 9'h1ff;
    // Password payload layout, word indexes.
    localparam logic [7:0] PW_CTRL_WORD    = 8'h00;
    localparam logic [7:0] PW_FIRST_WORD   = 8'h01;
    localparam logic [7:0] PW_LAST_WORD    = 8'h10;
    localparam int unsigned PW_WORDS       = 16;
    // Handler states.
    typedef enum logic [2:0] {
        SCH_IDLE,
        SCH_EXEC,
        SCH_SEND,
        SCH_PW_RECV,
        SCH_DONE
    } sch_state_t;
endpackage

// file: rtl/sch_data_rom.sv
`timescale 1ns/1ps
// Byte source for the 512-byte health data structure.
module sch_data_rom (
    // Selection.
    input  wire logic [8:0] idx,
    input  wire logic [7:0] checksum,
    // Field contents.
    input  wire logic [15:0] revision,
    input  wire logic [7:0]  offl_status,
    input  wire logic [7:0]  test_status,
    input  wire logic [15:0] offl_time,
    input  wire logic        errlog_supported,
    input  wire logic [7:0]  poll_short,
    input  wire logic [7:0]  poll_ext,
    input  wire logic [7:0]  poll_conv,
    // Selected byte.
    output logic [7:0]       byte_out
);
    // Fixed fields come from inputs; every other byte reads as zero.
    always_comb begin
        unique case (idx)
            sch_pkg::B_REV_LO:     byte_out = revision[7:0];
            sch_pkg::B_REV_HI:     byte_out = revision[15:8];
            sch_pkg::B_OFFL_STAT:  byte_out = offl_status;
            sch_pkg::B_TEST_STAT:  byte_out = test_status;
            sch_pkg::B_TIME_LO:    byte_out = offl_time[7:0];
            sch_pkg::B_TIME_HI:    byte_out = offl_time[15:8];
            sch_pkg::B_ERRLOG_CAP: byte_out = {7'h00, errlog_supported};
            sch_pkg::B_POLL_SHORT: byte_out = poll_short;
            sch_pkg::B_POLL_EXT:   byte_out = poll_ext;
            sch_pkg::B_POLL_CONV:  byte_out = poll_conv;
            sch_pkg::B_CHECKSUM:   byte_out = checksum;
            default:               byte_out = 8'h00;
        endcase
    end
endmodule

// file: rtl/sch_pw_check.sv
`timescale 1ns/1ps
// Compares an incoming password payload with the stored user or master password.
module sch_pw_check #(
    parameter int unsigned WORDS = 16
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Payload stream.
    input  wire logic        start,
    input  wire logic        word_vld,
    input  wire logic [7:0]  word_idx,
    input  wire logic [15:0] word_data,
    // Stored passwords.
    input  wire logic [WORDS*16-1:0] user_pw,
    input  wire logic [WORDS*16-1:0] master_pw,
    // Comparison result.
    output logic             match
);
    logic       use_master_q;  // Identifier bit from the control word.
    logic       use_master_d;
    logic       mism_q;        // Any password word differed so far.
    logic       mism_d;
    logic [15:0] ref_word;     // Stored word selected for this index.
    logic [7:0]  rel_idx;      // Index within the password field.

    // Selects the stored word and tracks any mismatch.
    always_comb begin
        use_master_d = use_master_q;
        mism_d       = mism_q;
        rel_idx      = word_idx - sch_pkg::PW_FIRST_WORD;
        ref_word     = 16'h0000;
        if (rel_idx < WORDS[7:0]) begin
            ref_word = use_master_q ? master_pw[rel_idx*16 +: 16] : user_pw[rel_idx*16 +: 16];
        end
        if (start) begin
            use_master_d = 1'b0;
            mism_d       = 1'b0;
        end else if (word_vld && word_idx == sch_pkg::PW_CTRL_WORD) begin
            use_master_d = word_data[0];
        end else if (word_vld && word_idx >= sch_pkg::PW_FIRST_WORD && word_idx <= sch_pkg::PW_LAST_WORD) begin
            if (word_data != ref_word) begin
                mism_d = 1'b1;
            end
        end
    end

    // Registers the comparison state.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            use_master_q <= 1'b0;
            mism_q       <= 1'b0;
        end else begin
            use_master_q <= use_master_d;
            mism_q       <= mism_d;
        end
    end

    // A full payload matches when no password word differed.
    assign match = !mism_q;
endmodule

// file: rtl/sch_handler.sv
`timescale 1ns/1ps
// Health-monitoring command handler with password-disable payload checking.
module sch_handler #(
    parameter logic [15:0] REVISION     = 16'h0001,
    parameter logic [7:0]  POLL_SHORT   = 8'h02,
    parameter logic [7:0]  POLL_EXT     = 8'h0a,
    parameter logic [7:0]  POLL_CONV    = 8'h05,
    parameter logic [15:0] OFFL_TIME    = 16'h0000,
    parameter int unsigned PW_WORDS     = 16
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Task-file inputs.
    input  wire logic        cmd_wr,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [7:0]  features,
    input  wire logic [7:0]  lba_mid,
    input  wire logic [7:0]  lba_high,
    input  wire logic        devsel_wr,
    input  wire logic [7:0]  devsel_wdata,
    // Device conditions.
    input  wire logic [7:0]  offl_status,
    input  wire logic [7:0]  test_status,
    input  wire logic        errlog_supported,
    // Password disable payload stream, lock request and stored passwords.
    input  wire logic        pw_start,
    input  wire logic        pw_word_vld,
    input  wire logic [15:0] pw_word,
    input  wire logic        lock_set,
    input  wire logic [PW_WORDS*16-1:0] user_pw,
    input  wire logic [PW_WORDS*16-1:0] master_pw,
    // Data-in stream to the host.
    input  wire logic        rd_ack,
    output logic [7:0]       rd_byte,
    output logic             rd_vld,
    // Task-file outputs.
    output logic [7:0]       task_completion_status,
    output logic [7:0]       task_error,
    output logic [7:0]       task_device_select,
    // Device state.
    output logic             health_enabled,
    output logic             lock_active,
    output logic             pw_done
);
    // Registered state; each _d is the next value of its _q.
    sch_pkg::sch_state_t state_q, state_d;  // Command phase.
    logic [7:0]  status_q,  status_d;       // Status register.
    logic [7:0]  error_q,   error_d;        // Error register.
    logic [7:0]  devsel_q,  devsel_d;       // Device select register.
    logic        en_q,      en_d;           // Feature enabled flag.
    logic        lock_q,    lock_d;         // Lock mode.
    logic [7:0]  feat_q,    feat_d;         // Latched sub-operation.
    logic        sig_ok_q,  sig_ok_d;       // Latched signature check.
    logic [8:0]  idx_q,     idx_d;          // Byte index of the sector.
    logic [7:0]  sum_q,     sum_d;          // Running byte sum.
    logic [7:0]  rd_byte_q, rd_byte_d;      // Byte presented to the host.
    logic        rd_vld_q,  rd_vld_d;       // Byte valid.
    logic [7:0]  pw_idx_q,  pw_idx_d;       // Payload word counter.
    logic        pw_done_q, pw_done_d;      // Payload finished pulse.
    logic [7:0]  rom_byte;                  // Structure byte at idx_d.
    logic        pw_match;                  // Password compare result.
    logic [7:0]  chk;                       // Checksum for the last byte.

    // Status shown while a command runs: busy set, ready carried over, the rest clear.
    function automatic logic [7:0] busy_status(input logic [7:0] cur);
        logic [7:0] st;  // Status being built.
        st                   = 8'h00;
        st[sch_pkg::ST_BSY]  = 1'b1;
        st[sch_pkg::ST_DRDY] = cur[sch_pkg::ST_DRDY];
        return st;
    endfunction

    // Checksum is the two's complement of the sum of the first 511 bytes.
    // It only replaces the table's own byte at the last position of the sector.
    assign chk = 8'h00 - sum_q;

    // Structure contents.
    // The table is addressed by the next index, so each byte is ready with it.
    sch_data_rom u_rom (
        .idx              (idx_d),
        .checksum         (chk),
        .revision         (REVISION),
        .offl_status      (offl_status),
        .test_status      (test_status),
        .offl_time        (OFFL_TIME),
        .errlog_supported (errlog_supported),
        .poll_short       (POLL_SHORT),
        .poll_ext         (POLL_EXT),
        .poll_conv        (POLL_CONV),
        .byte_out         (rom_byte)
    );

    // Password payload comparison.
    // It shares the word counter that also ends the payload.
    sch_pw_check #(
        .WORDS (PW_WORDS)
    ) u_pw (
        .clk       (clk),
        .rstn      (rstn),
        .start     (pw_start),
        .word_vld  (pw_word_vld),
        .word_idx  (pw_idx_q),
        .word_data (pw_word),
        .user_pw   (user_pw),
        .master_pw (master_pw),
        .match     (pw_match)
    );

    // Next-state logic for the whole handler.
    // Every register except pw_done_q keeps its value unless a branch below changes it; pw_done_q defaults to zero.
    always_comb begin
        state_d   = state_q;
        status_d  = status_q;
        error_d   = error_q;
        devsel_d  = devsel_q;
        en_d      = en_q;
        lock_d    = lock_q;
        feat_d    = feat_q;
        sig_ok_d  = sig_ok_q;
        idx_d     = idx_q;
        sum_d     = sum_q;
        rd_byte_d = rd_byte_q;
        rd_vld_d  = rd_vld_q;
        pw_idx_d  = pw_idx_q;
        pw_done_d = 1'b0;
        unique case (state_q)
            sch_pkg::SCH_IDLE: begin
                // Device select is only written while idle.
                if (devsel_wr) begin
                    devsel_d = devsel_wdata;
                end
                // A payload start wins over a command written in the same cycle.
                if (pw_start) begin
                    // Busy for the whole payload; an old abort must not leak into this result.
                    pw_idx_d = 8'h00;
                    status_d = busy_status(status_q);
                    error_d  = 8'h00;
                    state_d  = sch_pkg::SCH_PW_RECV;
                end else if (cmd_wr && cmd_code == sch_pkg::CMD_HEALTH) begin
                    // Features and signature are captured now, so later writes cannot disturb them.
                    feat_d   = features;
                    sig_ok_d = (lba_mid == sch_pkg::SIG_MID) && (lba_high == sch_pkg::SIG_HIGH);
                    status_d = busy_status(status_q);
                    error_d  = 8'h00;
                    state_d  = sch_pkg::SCH_EXEC;
                end
            end
            sch_pkg::SCH_EXEC: begin
                // Abort on bad signature, unmet prerequisite or unknown selector.
                // The signature and ready checks come first and cover every selector.
                state_d = sch_pkg::SCH_DONE;
                if (!sig_ok_q || !status_q[sch_pkg::ST_DRDY]) begin
                    error_d[sch_pkg::ER_ABRT] = 1'b1;
                end else begin
                    unique case (feat_q)
                        sch_pkg::SUB_READ_DATA: begin
                            // Read: byte 0 is fetched here so it already stands when valid rises.
                            if (en_q) begin
                                idx_d    = 9'h000;
                                sum_d    = 8'h00;
                                rd_byte_d = rom_byte;
                                rd_vld_d = 1'b1;
                                status_d[sch_pkg::ST_DRQ] = 1'b1;
                                state_d  = sch_pkg::SCH_SEND;
                            end else begin
                                // Reading is refused while the feature is off.
                                error_d[sch_pkg::ER_ABRT] = 1'b1;
                            end
                        end
                        sch_pkg::SUB_ENABLE: begin
                            // Enable needs only the signature and the ready bit, already checked above.
                            en_d = 1'b1;
                        end
                        sch_pkg::SUB_DISABLE: begin
                            // Disable is refused unless the feature is on.
                            if (en_q) begin
                                en_d = 1'b0;
                            end else begin
                                error_d[sch_pkg::ER_ABRT] = 1'b1;
                            end
                        end
                        default: begin
                            // Any other selector is unknown and aborts.
                            error_d[sch_pkg::ER_ABRT] = 1'b1;
                        end
                    endcase
                end
            end
            sch_pkg::SCH_SEND: begin
                // One byte per host acknowledge, 512 bytes in all.
                if (rd_ack) begin
                    sum_d = sum_q + rd_byte_q;
                    // The byte just taken was the last one: drop valid and finish.
                    if (idx_q == 9'(sch_pkg::SEC_BYTES - 1)) begin
                        rd_vld_d = 1'b0;
                        state_d  = sch_pkg::SCH_DONE;
                    end else begin
                        // The last byte takes the negated running sum instead of the table byte.
                        idx_d     = idx_q + 9'h001;
                        rd_byte_d = (idx_d == sch_pkg::B_CHECKSUM) ? (8'h00 - sum_d) : rom_byte;
                    end
                end
            end
            sch_pkg::SCH_PW_RECV: begin
                // Count payload words; decide after the last one.
                if (pw_word_vld) begin
                    // The compare is final here; the reserved tail words are only counted.
                    if (pw_idx_q == 8'hff) begin
                        state_d   = sch_pkg::SCH_DONE;
                        pw_done_d = 1'b1;
                        if (pw_match) begin
                            lock_d = 1'b0;
                        end else begin
                            // A wrong password leaves lock mode as it was and aborts.
                            error_d[sch_pkg::ER_ABRT] = 1'b1;
                        end
                    end else begin
                        pw_idx_d = pw_idx_q + 8'h01;
                    end
                end
            end
            sch_pkg::SCH_DONE: begin
                // Completion: busy, fault and request cleared, ready set.
                status_d = 8'h00;
                status_d[sch_pkg::ST_DRDY] = 1'b1;
                status_d[sch_pkg::ST_ERR]  = error_q[sch_pkg::ER_ABRT];
                // The device select keeps the value written before the command.
                devsel_d = devsel_q;
                state_d  = sch_pkg::SCH_IDLE;
            end
            default: begin
                state_d = sch_pkg::SCH_IDLE;
            end
        endcase
        // Lock mode can be raised by the set-password path at any time.
        // It is applied last so that a set in the same cycle as an unlock wins.
        if (lock_set) begin
            lock_d = 1'b1;
        end
    end

    // Registers the handler state.
    // Reset is synchronous, so it only takes effect on a clock edge.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q   <= sch_pkg::SCH_IDLE;
            status_q  <= sch_pkg::STATUS_RST;
            error_q   <= sch_pkg::ERROR_RST;
            devsel_q  <= sch_pkg::DEVSEL_RST;
            en_q      <= 1'b0;
            lock_q    <= 1'b0;
            feat_q    <= 8'h00;
            sig_ok_q  <= 1'b0;
            idx_q     <= 9'h000;
            sum_q     <= 8'h00;
            rd_byte_q <= 8'h00;
            rd_vld_q  <= 1'b0;
            pw_idx_q  <= 8'h00;
            pw_done_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            status_q  <= status_d;
            error_q   <= error_d;
            devsel_q  <= devsel_d;
            en_q      <= en_d;
            lock_q    <= lock_d;
            feat_q    <= feat_d;
            sig_ok_q  <= sig_ok_d;
            idx_q     <= idx_d;
            sum_q     <= sum_d;
            rd_byte_q <= rd_byte_d;
            rd_vld_q  <= rd_vld_d;
            pw_idx_q  <= pw_idx_d;
            pw_done_q <= pw_done_d;
        end
    end

    // All outputs come straight from registers.
    // Nothing is decoded on the way out, so no output can glitch between edges.
    assign rd_byte                = rd_byte_q;
    assign rd_vld                 = rd_vld_q;
    assign task_completion_status = status_q;
    assign task_error             = error_q;
    assign task_device_select     = devsel_q;
    assign health_enabled         = en_q;
    assign lock_active            = lock_q;
    assign pw_done                = pw_done_q;
endmodule

// file: dv/sch_checker.sv
// Concurrent checks on the health command handler ports.
`timescale 1ns/1ps
module sch_checker (
    // Clock and reset.
    input wire logic       clk,
    input wire logic       rstn,
    // Task-file inputs and the lock request.
    input wire logic       cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] features,
    input wire logic [7:0] lba_mid,
    input wire logic [7:0] lba_high,
    input wire logic       lock_set,
    // Outputs and the read acknowledge.
    input wire logic       rd_ack,
    input wire logic       rd_vld,
    input wire logic [7:0] rd_byte,
    input wire logic [7:0] task_completion_status,
    input wire logic [7:0] task_error,
    input wire logic       health_enabled,
    input wire logic       lock_active,
    input wire logic       pw_done
);
    logic [7:0] st;  // Short alias of the status byte.
    logic       go;  // A well-formed command taken while idle.
    assign st = task_completion_status;
    assign go = cmd_wr && cmd_code == sch_pkg::CMD_HEALTH && !st[sch_pkg::ST_BSY] && !st[sch_pkg::ST_DRQ]
        && lba_mid == sch_pkg::SIG_MID && lba_high == sch_pkg::SIG_HIGH;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_busy_taken: assert property (go |=> st[sch_pkg::ST_BSY]) else $error("busy not raised");
    a_enable_sets: assert property (go && features == sch_pkg::SUB_ENABLE |-> ##3 health_enabled)
        else $error("enable did not set flag");
    a_disable_clrs: assert property (go && features == sch_pkg::SUB_DISABLE && health_enabled
        |-> ##3 !health_enabled && !st[sch_pkg::ST_ERR]) else $error("disable did not clear flag");
    a_read_refused: assert property (go && features == sch_pkg::SUB_READ_DATA && !health_enabled
        |-> ##3 st[sch_pkg::ST_ERR] && !rd_vld) else $error("read accepted while disabled");
    a_unknown_abort: assert property (go && !(features inside {8'hd0, 8'hd8, 8'hd9})
        |-> ##3 st[sch_pkg::ST_ERR] && task_error[sch_pkg::ER_ABRT]) else $error("unknown value not aborted");
    a_read_start: assert property (go && features == sch_pkg::SUB_READ_DATA && health_enabled
        |-> ##2 rd_vld && st[sch_pkg::ST_DRQ]) else $error("read data not offered");
    a_byte_holds: assert property (rd_vld && !rd_ack |=> rd_vld && $stable(rd_byte))
        else $error("data byte dropped");
    a_done_clean: assert property ($fell(st[sch_pkg::ST_BSY]) |-> st[sch_pkg::ST_DRDY] && !st[sch_pkg::ST_DF]
        && st[sch_pkg::ST_ERR] == task_error[sch_pkg::ER_ABRT]) else $error("completion status wrong");
    a_lock_stays: assert property (!lock_active && !lock_set && !$past(lock_set) |=> !lock_active)
        else $error("lock set without request");
    // Main scenarios reached.
    c_enable: cover property (go && features == sch_pkg::SUB_ENABLE);
    c_ack: cover property (rd_vld && rd_ack);
    c_pw: cover property (pw_done);
endmodule

// file: dv/sch_host.sv
// Host model: issues commands, reads sectors and sends password payloads.
`timescale 1ns/1ps
module sch_host (
    // Clock.
    input wire logic        clk,
    // Task-file writes.
    output logic            cmd_wr,
    output logic [7:0]      cmd_code,
    output logic [7:0]      features,
    output logic [7:0]      lba_mid,
    output logic [7:0]      lba_high,
    output logic            devsel_wr,
    output logic [7:0]      devsel_wdata,
    // Password payload.
    output logic            pw_start,
    output logic            pw_word_vld,
    output logic [15:0]     pw_word,
    // Data-in handshake.
    input wire logic        rd_vld,
    input wire logic [7:0]  rd_byte,
    output logic            rd_ack
);
    logic [7:0] sec [512];  // Last sector read.
    initial begin
        {cmd_wr, devsel_wr, pw_start, pw_word_vld, rd_ack} = '0;
        {cmd_code, features, lba_mid, lba_high, devsel_wdata, pw_word} = '0;
    end
    // Selects the device, then loads features and signature and writes the opcode in the same cycle.
    task automatic cmd(input logic [7:0] dev, input logic [7:0] feat, input logic sig);
        @(negedge clk);
        devsel_wr = 1'b1;
        devsel_wdata = dev;
        @(negedge clk);
        devsel_wr = 1'b0;
        features = feat;
        lba_mid = sig ? sch_pkg::SIG_MID : 8'h00;
        lba_high = sch_pkg::SIG_HIGH;
        cmd_code = sch_pkg::CMD_HEALTH;
        cmd_wr = 1'b1;
        @(negedge clk);
        cmd_wr = 1'b0;
        cmd_code = ~cmd_code;
    endtask
    // Takes 512 bytes, stalling one more than the given number of cycles between them.
    task automatic rd_sec(input int slow);
        for (int i = 0; i < 512; i++) begin
            while (!rd_vld) @(negedge clk);
            sec[i] = rd_byte;
            rd_ack = 1'b1;
            @(negedge clk);
            rd_ack = 1'b0;
            repeat (1 + slow) @(negedge clk);
        end
    endtask
    // Sends a 256-word payload: control word, 16 password words, zeros.
    task automatic pw(input logic [15:0] ctrl, input logic [255:0] pwd);
        @(negedge clk);
        pw_start = 1'b1;
        @(negedge clk);
        pw_start = 1'b0;
        for (int w = 0; w < 256; w++) begin
            pw_word = (w == 0) ? ctrl : (w <= 16) ? pwd[(w-1)*16 +: 16] : 16'h0000;
            pw_word_vld = 1'b1;
            @(negedge clk);
            pw_word_vld = 1'b0;
            pw_word = ~pw_word;
            @(negedge clk);
        end
    endtask
endmodule

// file: dv/sch_handler_tb.sv
// Self-checking bench for the health command handler.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module sch_handler_tb;
    logic clk, rstn, cmd_wr, devsel_wr, errlog_supported, pw_start, pw_word_vld, lock_set, rd_ack, rd_vld;
    logic health_enabled, lock_active, pw_done;
    logic [7:0] cmd_code, features, lba_mid, lba_high, devsel_wdata, offl_status, test_status, rd_byte;
    logic [7:0] task_completion_status, task_error, task_device_select;
    logic [15:0] pw_word;
    logic [255:0] user_pw, master_pw;
    int errors, n_tests, cycles, pw_seen;
    logic [7:0] sum;
    sch_handler #(.REVISION(16'h1203), .POLL_SHORT(8'h07), .POLL_EXT(8'h21), .POLL_CONV(8'h0c),
        .OFFL_TIME(16'h012c)) dut_u (.*);
    sch_host host_u (.clk, .cmd_wr, .cmd_code, .features, .lba_mid, .lba_high, .devsel_wr, .devsel_wdata,
        .pw_start, .pw_word_vld, .pw_word, .rd_vld, .rd_byte, .rd_ack);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Cuts a hang short and counts completion pulses.
    always @(posedge clk) begin
        cycles++;
        pw_seen += pw_done;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Issues a command and checks the final status.
    task automatic run(input logic [7:0] dev, feat, input logic sig, input logic [7:0] exp);
        host_u.cmd(dev, feat, sig);
        repeat (4) @(negedge clk);
        `CHK("status", exp, task_completion_status)
        if (exp[0]) `CHK("abrt", 1'b1, task_error[2])
    endtask
    initial begin
        {rstn, lock_set, errlog_supported} = '0;
        {offl_status, test_status} = {8'h82, 8'h19};
        user_pw = {16{16'ha5c3}};
        master_pw = {8{32'h0f1e2d3c}};
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        `CHK("rst", 17'h08000, {task_completion_status, task_error, health_enabled})
        run(8'h00, 8'hd0, 1'b1, 8'h41);
        run(8'h00, 8'h00, 1'b1, 8'h41);
        run(8'h00, 8'hda, 1'b1, 8'h41);
        run(8'h00, 8'hd8, 1'b0, 8'h41);
        run(8'h10, 8'hd8, 1'b1, 8'h40);
        `CHK("en", 1'b1, health_enabled)
        `CHK("dev", 1'b1, task_device_select[4])
        for (int k = 0; k < 2; k++) begin
            errlog_supported = (k == 0);
            test_status = 8'h19 + k[7:0];
            host_u.cmd(k ? 8'h00 : 8'h10, 8'hd0, 1'b1);
            host_u.rd_sec(k * 3);
            repeat (2) @(negedge clk);
            `CHK("status", 8'h40, task_completion_status)
            `CHK("dev", k == 0, task_device_select[4])
            sum = 8'h00;
            foreach (host_u.sec[i]) sum += host_u.sec[i];
            `CHK("sum", 8'h00, sum)
            `CHK("rev", 16'h1203, {host_u.sec[1], host_u.sec[0]})
            `CHK("stat", {8'h82, test_status}, {host_u.sec[362], host_u.sec[363]})
            `CHK("time", 16'h012c, {host_u.sec[365], host_u.sec[364]})
            `CHK("log", {7'h0, errlog_supported}, host_u.sec[370])
            `CHK("poll", 24'h07210c, {host_u.sec[372], host_u.sec[373], host_u.sec[374]})
        end
        run(8'h00, 8'hd9, 1'b1, 8'h40);
        `CHK("en", 1'b0, health_enabled)
        run(8'h00, 8'hd9, 1'b1, 8'h41);
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            lock_set = (k < 2);
            @(negedge clk);
            lock_set = 1'b0;
            host_u.pw({15'h0, k == 0}, k == 2 ? user_pw : master_pw);
            repeat (6) @(negedge clk);
            `CHK("done", k + 1, pw_seen)
            `CHK("lock", k == 1, lock_active)
            `CHK("abrt", k == 1, task_error[2])
            `CHK("pwst", (k == 1) ? 8'h41 : 8'h40, task_completion_status)
        end
        report_and_stop();
    end
endmodule
bind sch_handler sch_checker chk_u (.clk, .rstn, .cmd_wr, .cmd_code, .features, .lba_mid, .lba_high, .lock_set,
    .rd_ack, .rd_vld, .rd_byte, .task_completion_status, .task_error, .health_enabled, .lock_active, .pw_done);
